// file: bvpr_regs.sv
// Operation
// - Each rail keeps a 7-bit ceiling code loaded from OTP, read-only except in test mode.
// - Every 7-bit voltage code is linear, 0 is 0.30 V, each step adds 0.01 V, 7'h7f is 1.57 V.
// - Rail A on its first setting runs PWM when bit 7 of that register is 0 and automatic when 1.
// - Rail A on its second setting runs PWM when bit 7 of that register is 0 and automatic when 1.
// - Rail B on its first setting runs PWM when bit 7 of that register is 0 and automatic when 1.
// - Rail B on its second setting runs PWM when bit 7 of that register is 0 and automatic when 1.
// - The per-setting bit only counts when the rail's operating style field is 00.
// - With the auto return bit set, the page field goes back to 000 when an access completes.
// - Page control bit 6 picks page write (0) or repeated write (1) for two-wire bursts.
// - Two-wire pages ignore the page field's low bit: 00x, 01x and 10x map three windows.
// - Four-wire pages map 128 registers each for page values 000, 001, 010 and 100.
`timescale 1ns/10ps
`default_nettype none

module bvpr_regs
	import bvpr_pkg::*;
#(
	parameter logic [7:0] TARGET_RESET = BVPR_RST_TARGET
) (
	// Clock, reset and enable
	input  wire logic       clock_i,
	input  wire logic       resetn_i,
	input  wire logic       enable_i,
	// Register access from the serial interface logic
	input  wire logic [7:0] acc_offset_i,
	input  wire logic       acc_wr_i,
	input  wire logic       acc_rd_i,
	input  wire logic [7:0] acc_wdata_i,
	input  wire logic       acc_end_i,
	input  wire logic       four_wire_i,
	input  wire logic       test_mode_i,
	output logic [7:0]      acc_rdata_o,
	output logic            acc_hit_o,
	// OTP load
	input  wire logic       otp_load_i,
	input  wire logic [6:0] otp_ceil_a_i,
	input  wire logic [6:0] otp_ceil_b_i,
	// Regulator control
	input  wire logic       rail_a_second_sel_i,
	input  wire logic       rail_b_second_sel_i,
	input  wire logic [1:0] rail_a_operating_style_i,
	input  wire logic [1:0] rail_b_operating_style_i,
	output logic [6:0]      rail_a_target_code_o,
	output logic [6:0]      rail_b_target_code_o,
	output logic            rail_a_auto_o,
	output logic            rail_b_auto_o,
	// Page control view
	output logic [2:0]      page_select_o,
	output logic            repeated_write_o
);

	// ==========================================================
	// Helpers

	// Map a windowed offset to a full register address.
	function automatic bvpr_map_t map_offset(input logic [2:0] page,
		input logic [7:0] ofs, input logic four_wire);
		bvpr_map_t m;
		logic [9:0] low7;
		m    = '{hit: 1'b0, addr: BVPR_BASE_P0};
		low7 = {3'h0, ofs[BVPR_OFS_MSB:0]};
		if (four_wire) begin
			m.hit = 1'b1;
			case (page)
				BVPR_PAGE_0: m.addr = BVPR_BASE_P0 | low7;
				BVPR_PAGE_1: m.addr = BVPR_BASE_P1 | low7;
				BVPR_PAGE_2: m.addr = BVPR_BASE_P2 | low7;
				BVPR_PAGE_4: m.addr = BVPR_BASE_P4 | low7;
				default:     m.hit  = 1'b0;
			endcase
		end else begin
			// The low page bit is a don't care here.
			case (page[2:1])
				BVPR_TW_LOW: begin
					m.hit  = 1'b1;
					m.addr = BVPR_BASE_P0 | {2'h0, ofs};
				end
				BVPR_TW_MID: begin
					m.hit  = ~ofs[7];
					m.addr = BVPR_BASE_P2 | low7;
				end
				BVPR_TW_HIGH: begin
					m.hit  = ~ofs[7];
					m.addr = BVPR_BASE_P4 | low7;
				end
				default: m.hit = 1'b0;
			endcase
		end
		return m;
	endfunction

	// Limit a target code to the rail's ceiling.
	function automatic logic [6:0] clamp(input logic [6:0] code,
		input logic [6:0] ceil);
		return (code > ceil) ? ceil : code;
	endfunction

	// Resolve PWM or automatic operation for a rail.
	function automatic logic auto_sel(input logic [1:0] style,
		input logic setting_bit);
		logic r;
		r = 1'b0;
		case (style)
			BVPR_STYLE_PER_SETTING: r = setting_bit;
			BVPR_STYLE_AUTO_ONE:    r = 1'b1;
			BVPR_STYLE_PWM:         r = 1'b0;
			BVPR_STYLE_AUTO:        r = 1'b1;
			default:                r = 1'b0;
		endcase
		return r;
	endfunction

	// ==========================================================
	// State

	bvpr_state_t st;
	bvpr_state_t next_st;
	bvpr_map_t   acc_map;
	logic [7:0]  read_val;
	logic [6:0]  a_code;
	logic [6:0]  b_code;
	logic        a_bit;
	logic        b_bit;

	assign acc_map = map_offset(st.pctl.page, acc_offset_i, four_wire_i);

	// Readback view; reserved bits are zero.
	always_comb begin
		read_val = BVPR_RST_BYTE;
		if (acc_map.hit) begin
			unique case (acc_map.addr)
				BVPR_ADDR_CEIL_A:   read_val = {1'b0, st.ceil_a};
				BVPR_ADDR_CEIL_B:   read_val = {1'b0, st.ceil_b};
				BVPR_ADDR_A_FIRST:  read_val = st.a_first;
				BVPR_ADDR_A_SECOND: read_val = st.a_second;
				BVPR_ADDR_B_FIRST:  read_val = st.b_first;
				BVPR_ADDR_B_SECOND: read_val = st.b_second;
				BVPR_ADDR_PAGE,
				BVPR_ADDR_PAGE_LOW: read_val = {st.pctl.auto_return,
					st.pctl.write_style, 3'h0, st.pctl.page};
				default:            read_val = BVPR_RST_BYTE;
			endcase
		end
	end

	// ==========================================================
	// Next state

	always_comb begin
		next_st = st;
		if (otp_load_i) begin
			next_st.ceil_a = otp_ceil_a_i;
			next_st.ceil_b = otp_ceil_b_i;
		end
		if (acc_rd_i) begin
			next_st.rdata = read_val;
		end
		if (acc_wr_i && acc_map.hit) begin
			unique case (acc_map.addr)
				BVPR_ADDR_CEIL_A: begin
					if (test_mode_i) begin
						next_st.ceil_a = acc_wdata_i[BVPR_CODE_MSB:0];
					end
				end
				BVPR_ADDR_CEIL_B: begin
					if (test_mode_i) begin
						next_st.ceil_b = acc_wdata_i[BVPR_CODE_MSB:0];
					end
				end
				BVPR_ADDR_A_FIRST:  next_st.a_first  = acc_wdata_i;
				BVPR_ADDR_A_SECOND: next_st.a_second = acc_wdata_i;
				BVPR_ADDR_B_FIRST:  next_st.b_first  = acc_wdata_i;
				BVPR_ADDR_B_SECOND: next_st.b_second = acc_wdata_i;
				BVPR_ADDR_PAGE,
				BVPR_ADDR_PAGE_LOW: begin
					next_st.pctl.auto_return =
						acc_wdata_i[BVPR_RETURN_BIT];
					next_st.pctl.write_style =
						acc_wdata_i[BVPR_WSTYLE_BIT];
					next_st.pctl.page = acc_wdata_i[2:0];
				end
				default: next_st.rdata = st.rdata;
			endcase
		end
		// The bit written in the closing access already counts, so a
		// single closing write that sets it returns the page to 000 at once.
		if (acc_end_i && next_st.pctl.auto_return) begin
			next_st.pctl.page = BVPR_RST_PAGE;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			st <= '{ceil_a: BVPR_RST_CEIL, ceil_b: BVPR_RST_CEIL,
				a_first: TARGET_RESET, a_second: TARGET_RESET,
				b_first: TARGET_RESET, b_second: TARGET_RESET,
				pctl: '{auto_return: 1'b0, write_style: 1'b0,
					page: BVPR_RST_PAGE},
				rdata: BVPR_RST_BYTE};
		end else if (enable_i) begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Rail outputs

	// Codes are only clamped to the ceiling, not rescaled; the regulator applies the linear
	// 0.30 V plus 0.01 V per step scale.
	always_comb begin
		a_code = rail_a_second_sel_i ? st.a_second[BVPR_CODE_MSB:0]
			: st.a_first[BVPR_CODE_MSB:0];
		b_code = rail_b_second_sel_i ? st.b_second[BVPR_CODE_MSB:0]
			: st.b_first[BVPR_CODE_MSB:0];
		a_bit = rail_a_second_sel_i ? st.a_second[BVPR_AUTO_BIT]
			: st.a_first[BVPR_AUTO_BIT];
		b_bit = rail_b_second_sel_i ? st.b_second[BVPR_AUTO_BIT]
			: st.b_first[BVPR_AUTO_BIT];
	end

	assign rail_a_target_code_o = clamp(a_code, st.ceil_a);
	assign rail_b_target_code_o = clamp(b_code, st.ceil_b);
	assign rail_a_auto_o = auto_sel(rail_a_operating_style_i, a_bit);
	assign rail_b_auto_o = auto_sel(rail_b_operating_style_i, b_bit);
	assign acc_rdata_o      = st.rdata;
	assign acc_hit_o        = acc_map.hit;
	assign page_select_o    = st.pctl.page;
	assign repeated_write_o = st.pctl.write_style;

endmodule

`default_nettype wire

// file: bvpr_pkg.sv
package bvpr_pkg;

	// ==========================================================
	// Full register addresses (page base plus offset)
	localparam logic [9:0] BVPR_ADDR_CEIL_A   = 10'h0d5;
	localparam logic [9:0] BVPR_ADDR_CEIL_B   = 10'h0d6;
	localparam logic [9:0] BVPR_ADDR_A_FIRST  = 10'h0d7;
	localparam logic [9:0] BVPR_ADDR_A_SECOND = 10'h0d8;
	localparam logic [9:0] BVPR_ADDR_B_FIRST  = 10'h0d9;
	localparam logic [9:0] BVPR_ADDR_B_SECOND = 10'h0da;
	localparam logic [9:0] BVPR_ADDR_PAGE     = 10'h100;
	localparam logic [9:0] BVPR_ADDR_PAGE_LOW = 10'h080;

	// ==========================================================
	// Page windows
	localparam logic [9:0] BVPR_BASE_P0 = 10'h000;
	localparam logic [9:0] BVPR_BASE_P1 = 10'h080;
	localparam logic [9:0] BVPR_BASE_P2 = 10'h100;
	localparam logic [9:0] BVPR_BASE_P4 = 10'h200;
	localparam logic [2:0] BVPR_PAGE_0  = 3'h0;
	localparam logic [2:0] BVPR_PAGE_1  = 3'h1;
	localparam logic [2:0] BVPR_PAGE_2  = 3'h2;
	localparam logic [2:0] BVPR_PAGE_4  = 3'h4;
	localparam logic [1:0] BVPR_TW_LOW  = 2'h0;
	localparam logic [1:0] BVPR_TW_MID  = 2'h1;
	localparam logic [1:0] BVPR_TW_HIGH = 2'h2;

	// ==========================================================
	// Field positions
	localparam int BVPR_AUTO_BIT   = 7;
	localparam int BVPR_RETURN_BIT = 7;
	localparam int BVPR_WSTYLE_BIT = 6;
	localparam int BVPR_CODE_MSB   = 6;
	localparam int BVPR_OFS_MSB    = 6;

	// Operating style field values.
	localparam logic [1:0] BVPR_STYLE_PER_SETTING = 2'h0;
	localparam logic [1:0] BVPR_STYLE_AUTO_ONE    = 2'h1;
	localparam logic [1:0] BVPR_STYLE_PWM         = 2'h2;
	localparam logic [1:0] BVPR_STYLE_AUTO        = 2'h3;

	// Code 0 is 0.30 V, steps of 0.01 V, 7'h7f is 1.57 V.
	localparam int BVPR_CODE_BASE_MV = 300;
	localparam int BVPR_CODE_STEP_MV = 10;

	// ==========================================================
	// Reset values
	localparam logic [6:0] BVPR_RST_CEIL   = 7'h7f;
	localparam logic [7:0] BVPR_RST_TARGET = 8'h00;
	localparam logic [7:0] BVPR_RST_BYTE   = 8'h00;
	localparam logic [2:0] BVPR_RST_PAGE   = 3'h0;

	// Page control register contents.
	typedef struct packed {
		logic       auto_return;
		logic       write_style;
		logic [2:0] page;
	} bvpr_page_t;

	// Result of mapping a windowed offset to a full address.
	typedef struct packed {
		logic       hit;
		logic [9:0] addr;
	} bvpr_map_t;

	// Whole state of the register bank.
	typedef struct packed {
		logic [6:0] ceil_a;
		logic [6:0] ceil_b;
		logic [7:0] a_first;
		logic [7:0] a_second;
		logic [7:0] b_first;
		logic [7:0] b_second;
		bvpr_page_t pctl;
		logic [7:0] rdata;
	} bvpr_state_t;

endpackage

// file: bvpr_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker for the register bank.
module bvpr_checker (
	// Watched ports
	input wire logic       clock_i,
	input wire logic       resetn_i,
	input wire logic       enable_i,
	input wire logic [7:0] acc_offset_i,
	input wire logic       acc_wr_i,
	input wire logic       acc_rd_i,
	input wire logic [7:0] acc_wdata_i,
	input wire logic       acc_end_i,
	input wire logic       four_wire_i,
	input wire logic       otp_load_i,
	input wire logic [6:0] otp_ceil_a_i,
	input wire logic [1:0] rail_a_operating_style_i,
	input wire logic [1:0] rail_b_operating_style_i,
	input wire logic [7:0] acc_rdata_o,
	input wire logic       acc_hit_o,
	input wire logic [6:0] rail_a_target_code_o,
	input wire logic       rail_a_auto_o,
	input wire logic       rail_b_auto_o,
	input wire logic [2:0] page_select_o,
	input wire logic       repeated_write_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	wire logic [1:0] pg = page_select_o[2:1];

	// Two-wire write to the page control mirror while on page 00x.
	sequence s_pc_wr;
		enable_i && acc_wr_i && !four_wire_i && pg == 2'h0
			&& acc_offset_i == 8'h80;
	endsequence
	// The same write with the return bit set as the access closes.
	sequence s_pc_ret;
		s_pc_wr ##0 (acc_wdata_i[7] && acc_end_i);
	endsequence
	AST_PAGE_RETURN: assert property (s_pc_ret |=>
		page_select_o == 3'h0)
		else $error("page field not returned");
	AST_WRITE_STYLE: assert property (s_pc_wr |=>
		repeated_write_o == $past(acc_wdata_i[6]))
		else $error("write style bit wrong");
	AST_TW_MAP: assert property (!four_wire_i && (pg == 2'h0
		|| (pg != 2'h3 && !acc_offset_i[7])) |-> acc_hit_o)
		else $error("two-wire window missed");
	AST_TW_NONE: assert property (!four_wire_i && (pg == 2'h3
		|| (pg != 2'h0 && acc_offset_i[7])) |-> !acc_hit_o)
		else $error("two-wire hit outside window");
	AST_FW_MAP: assert property (four_wire_i |-> acc_hit_o ==
		(page_select_o inside {3'h0, 3'h1, 3'h2, 3'h4}))
		else $error("four-wire window wrong");
	AST_UNMAPPED_READ: assert property (
		enable_i && acc_rd_i && !acc_hit_o |=> acc_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!(enable_i && acc_rd_i) |=>
		$stable(acc_rdata_o))
		else $error("read data moved without read");
	AST_STYLE_A: assert property (rail_a_operating_style_i != 2'h0
		|-> rail_a_auto_o == (rail_a_operating_style_i != 2'h2))
		else $error("rail a style override wrong");
	AST_STYLE_B: assert property (rail_b_operating_style_i != 2'h0
		|-> rail_b_auto_o == (rail_b_operating_style_i != 2'h2))
		else $error("rail b style override wrong");
	AST_OTP_CLAMP: assert property (
		enable_i && otp_load_i && !acc_wr_i |=>
		rail_a_target_code_o <= $past(otp_ceil_a_i))
		else $error("target above new ceiling");
endmodule
bind bvpr_regs bvpr_checker u_chk (
	.clock_i                  (clock_i),
	.resetn_i                 (resetn_i),
	.enable_i                 (enable_i),
	.acc_offset_i             (acc_offset_i),
	.acc_wr_i                 (acc_wr_i),
	.acc_rd_i                 (acc_rd_i),
	.acc_wdata_i              (acc_wdata_i),
	.acc_end_i                (acc_end_i),
	.four_wire_i              (four_wire_i),
	.otp_load_i               (otp_load_i),
	.otp_ceil_a_i             (otp_ceil_a_i),
	.rail_a_operating_style_i (rail_a_operating_style_i),
	.rail_b_operating_style_i (rail_b_operating_style_i),
	.acc_rdata_o              (acc_rdata_o),
	.acc_hit_o                (acc_hit_o),
	.rail_a_target_code_o     (rail_a_target_code_o),
	.rail_a_auto_o            (rail_a_auto_o),
	.rail_b_auto_o            (rail_b_auto_o),
	.page_select_o            (page_select_o),
	.repeated_write_o         (repeated_write_o)
);
`default_nettype wire

// file: bvpr_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Serial interface side: one byte access per call.
module bvpr_host (
	// Clock and answer
	input wire logic  clock_i,
	input wire logic  hit_i,
	// Access request
	output logic [7:0] ofs_o,
	output logic       wr_o,
	output logic       rd_o,
	output logic [7:0] wd_o,
	output logic       end_o
);
	initial begin
		{ofs_o, wr_o, rd_o, wd_o, end_o} = '0;
	end
	// Released lines show the inverse byte, so a stale value never looks valid.
	task automatic acc(input logic w, input logic [7:0] o, d, input logic e, output logic h);
		@(negedge clock_i);
		{wr_o, rd_o, ofs_o, wd_o, end_o} = {w, !w, o, d, e};
		// Hit is taken while it is settled, before the edge that may
		// move the page under it.
		#5;
		h = hit_i;
		@(posedge clock_i);
		@(negedge clock_i);
		{wr_o, rd_o, ofs_o, wd_o, end_o} = {2'b00, ~o, ~d, 1'b0};
	endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import bvpr_pkg::*;
	logic clock_i = 0, resetn_i = 0, four_wire_i = 0, test_mode_i = 0;
	logic otp_load_i = 0, sa = 0, sb = 0, en = 1, hit, hit_w, aa, ab, rpt;
	logic [1:0] ma = 0, mb = 0;
	logic [6:0] oa = 0, ob = 0, ta, tb_;
	logic [7:0] rdata, m [0:1023], ol [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
	logic [2:0] psel;
	logic [31:0] r = 32'h94a8;
	wire logic [7:0] ofs, wd;
	wire logic wr, rd, aend;
	int num_errors = 0, check_count = 0;

	bvpr_regs u_dut (
		.clock_i(clock_i), .resetn_i(resetn_i), .enable_i(en),
		.acc_offset_i(ofs), .acc_wr_i(wr), .acc_rd_i(rd), .acc_wdata_i(wd),
		.acc_end_i(aend), .four_wire_i(four_wire_i), .test_mode_i(test_mode_i),
		.acc_rdata_o(rdata), .acc_hit_o(hit_w), .otp_load_i(otp_load_i),
		.otp_ceil_a_i(oa), .otp_ceil_b_i(ob),
		.rail_a_second_sel_i(sa), .rail_b_second_sel_i(sb),
		.rail_a_operating_style_i(ma), .rail_b_operating_style_i(mb),
		.rail_a_target_code_o(ta), .rail_b_target_code_o(tb_),
		.rail_a_auto_o(aa), .rail_b_auto_o(ab),
		.page_select_o(psel), .repeated_write_o(rpt)
	);
	bvpr_host u_host (.clock_i(clock_i), .hit_i(hit_w), .ofs_o(ofs),
		.wr_o(wr), .rd_o(rd), .wd_o(wd), .end_o(aend));

	initial begin
		forever #10 clock_i = ~clock_i;
	end
	function automatic logic [31:0] nxt(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// ==========================================================
	// Reference model: full address of an offset under the page.
	function automatic int map(input logic [7:0] o);
		int p = m[256][2:0];
		if (four_wire_i) return p inside {0, 1, 2, 4} ? p * 128 + o[6:0] : -1;
		if (p / 2 == 0) return o;
		return (p / 2 < 3 && !o[7]) ? p / 2 * 256 + o : -1;
	endfunction
	task automatic chk(input logic [7:0] got, exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic outs();
		logic [7:0] ca, cb;
		ca = sa ? m[216] : m[215];
		cb = sb ? m[218] : m[217];
		chk({1'b0, ta}, ca[6:0] < m[213] ? ca & 8'h7f : m[213]);
		chk({1'b0, tb_}, cb[6:0] < m[214] ? cb & 8'h7f : m[214]);
		chk({7'h0, aa}, {7'h0, ma == 0 ? ca[7] : ma != 2});
		chk({7'h0, ab}, {7'h0, mb == 0 ? cb[7] : mb != 2});
		chk({1'b0, rpt, 3'h0, psel}, m[256] & 8'h47);
	endtask
	task automatic go(input logic w, input logic [7:0] o, d, input logic e);
		int a;
		a = map(o);
		u_host.acc(w, o, d, e, hit);
		chk({7'h0, hit}, {7'h0, a >= 0});
		if (!w) chk(rdata, a == 128 ? m[256] : (a < 0 ? 8'h00 : m[a]));
		else if (!en) a = -1; // A frozen bank takes no write.
		else if (a == 213 || a == 214) begin
			if (test_mode_i) m[a] = d & 8'h7f;
		end else if (a >= 215 && a <= 218) m[a] = d;
		else if (a == 128 || a == 256) m[256] = d & 8'hc7;
		if (en && e && m[256][7]) m[256][2:0] = 3'h0;
		outs();
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// Main sequence.
	initial begin
		foreach (m[i]) m[i] = 8'h00;
		m[213] = 8'h7f;
		m[214] = 8'h7f;
		repeat (20) @(negedge clock_i);
		resetn_i = 1;
		outs();
		for (int a = 8'hd5; a <= 8'hda; a++) go(0, a[7:0], 8'h00, 0);
		repeat (80) begin
			r = nxt(r);
			{sa, sb, ma, mb, test_mode_i} = r[6:0];
			if (r[9:8] == 0) begin
				@(negedge clock_i);
				{otp_load_i, oa, ob} = {1'b1, r[30:17]};
				m[213] = {1'b0, r[30:24]};
				m[214] = {1'b0, r[23:17]};
				@(negedge clock_i);
				otp_load_i = 0;
			end
			en = |r[22:21];
			go(1, 8'hd5 + r[12:10] % 6, r[20:13], 0);
			en = 1;
			go(0, 8'hd5 + r[12:10] % 6, 8'h00, 0);
		end
		// A second reset mid-run must bring every register back.
		@(negedge clock_i);
		resetn_i = 0;
		repeat (2) @(negedge clock_i);
		resetn_i = 1;
		foreach (m[i]) m[i] = 8'h00;
		m[213] = 8'h7f;
		m[214] = 8'h7f;
		outs();
		test_mode_i = 0;
		go(1, 8'h80, 8'h7a, 0);
		go(0, 8'h00, 8'h00, 0);
		go(1, 8'h00, 8'h00, 0);
		go(1, 8'h80, 8'h83, 1);
		for (int i = 0; i < 16; i++) begin
			r = nxt(r);
			go(1, 8'h80, {1'b1, r[0], 3'h0, i[2:0]}, 0);
			four_wire_i = i[3];
			foreach (ol[k]) go(0, ol[k], 8'h00, 0);
			go(1, 8'hd7, r[8:1], 1);
			four_wire_i = 0;
		end
		summarize();
	end
	initial begin
		#200us;
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
